// ---- hw/plam_menu.sv ----
`timescale 1ns/1ns
`include "plam_defs.svh"
// Function
// - Output item: navigate to exit, select increase.
// - Increase raises output to upper limit.
// - Decrease lowers output to lower limit.
// - Store option saves output; navigate steps exit.
// - Step exit: navigate increase, select item.
// - Controller exit: navigate auto/manual, select tuning.
// - Tuning branch only when PID enabled.
// - Gain held as gain, range 0 to 100.
// - Integral in minutes, derivative in seconds.
// - Zero integral or derivative disables action.
// - Tuning entry: navigate quit, select gain.
// - Gain steps between 0 and limit.
// - Gain store saves gain; navigate steps exit.
// - Integral steps between zero and limit.
// - Integral store saves integral time.
// - Derivative steps between 0 and limit.
// - Derivative store saves; navigate steps exit.
// - Action item toggles direction; navigate exits.
// - Loop exit: navigate gain, select quit.
// - Quit: navigate test branch, select monitoring.
// - Auto/manual item toggles state, shows letter.
module plam_menu #(
    parameter int DEB_CYC  = `PLAM_DEB_CYC,
    parameter int REP_CYC  = `PLAM_REP_CYC,
    parameter int TIME_MAX = 16'hffff
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   nav_tool,
    input  wire logic                   sel_tool,
    input  wire logic                   pid_enabled,
    input  wire logic [15:0]            out_low_limit,
    input  wire logic [15:0]            out_high_limit,
    output plam_pkg::plam_menu_t        menu_state,
    output plam_pkg::plam_tuning_t      tuning,
    output plam_pkg::plam_store_t       store,
    output logic                        integral_active,
    output logic                        derivative_active,
    output logic                        local_active
);
    // Zero counts would stall the debouncer or the repeat timer, and the times are only 16 bits wide.
    if (DEB_CYC < 1) begin : g_bad_deb
        $error("plam_menu: DEB_CYC must be at least 1");
    end
    if (REP_CYC < 1) begin : g_bad_rep
        $error("plam_menu: REP_CYC must be at least 1");
    end
    if (TIME_MAX < 1 || TIME_MAX > 16'hffff) begin : g_bad_time
        $error("plam_menu: TIME_MAX must lie between 1 and 65535");
    end

    typedef struct packed {
        logic [1:0]             nav_sync;
        logic [1:0]             sel_sync;
        logic                   nav_deb;
        logic                   sel_deb;
        logic [31:0]            nav_cnt;
        logic [31:0]            sel_cnt;
        logic [31:0]            rep_cnt;
        logic                   rep_ok;
        plam_pkg::plam_menu_t   menu;
        plam_pkg::plam_tuning_t tune;
        plam_pkg::plam_store_t  store;
        logic                   int_act;
        logic                   der_act;
        logic                   local_on;
    } plam_state_t;

    logic [1:0]  rst_sync;
    logic        rst_int_b;
    plam_state_t r;
    plam_state_t next_r;

    // Saturating step of a 16-bit value; the bound is included.
    function automatic logic [15:0] plam_step(input logic [15:0] v, input logic up, input logic [15:0] lim);
        logic [15:0] res;
        res = v;
        if (up) begin
            if (v < lim) begin
                res = v + 16'h0001;
            end
        end else begin
            if (v > lim) begin
                res = v - 16'h0001;
            end
        end
        return res;
    endfunction : plam_step

    // Reset is taken at once but let go only after two clean clock edges.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync[1];

    always_comb begin
        logic nav_hit;
        logic sel_hit;
        logic rep_hit;
        logic [15:0] gain_wide;
        nav_hit = 1'b0;
        sel_hit = 1'b0;
        rep_hit = 1'b0;
        gain_wide = 16'h0000;
        next_r = r;
        // A store request lasts one cycle; the memory side latches the data with it.
        next_r.store.store_req = 1'b0;

        // A level must hold steady for the debounce time before it is believed.
        next_r.nav_sync = {r.nav_sync[0], nav_tool};
        next_r.sel_sync = {r.sel_sync[0], sel_tool};
        if (r.nav_sync[1] == r.nav_deb) begin
            next_r.nav_cnt = 32'h0;
        end else if (r.nav_cnt >= 32'(DEB_CYC - 1)) begin
            next_r.nav_cnt = 32'h0;
            next_r.nav_deb = r.nav_sync[1];
            nav_hit        = r.nav_sync[1];
        end else begin
            next_r.nav_cnt = r.nav_cnt + 32'h1;
        end
        if (r.sel_sync[1] == r.sel_deb) begin
            next_r.sel_cnt = 32'h0;
        end else if (r.sel_cnt >= 32'(DEB_CYC - 1)) begin
            next_r.sel_cnt = 32'h0;
            next_r.sel_deb = r.sel_sync[1];
            sel_hit        = r.sel_sync[1];
        end else begin
            next_r.sel_cnt = r.sel_cnt + 32'h1;
        end

        // The first step comes on insertion, the next ones once per repeat interval.
        if (!r.sel_deb || sel_hit) begin
            next_r.rep_cnt = 32'h0;
            rep_hit        = sel_hit;
        end else if (r.rep_cnt >= 32'(REP_CYC - 1)) begin
            next_r.rep_cnt = 32'h0;
            rep_hit        = r.rep_ok;
        end else begin
            next_r.rep_cnt = r.rep_cnt + 32'h1;
        end

        // The gain is stepped in a 16-bit copy so that one step function serves every value.
        gain_wide = {8'h00, r.tune.proportional_gain};
        // Navigate is looked at first, so it wins when both tools arrive together.
        case (r.menu)
            plam_pkg::M_OUT_ITEM: begin
                if (nav_hit) next_r.menu = plam_pkg::M_CTL_EXIT;
                else if (sel_hit) next_r.menu = plam_pkg::M_OUT_INC;
            end
            plam_pkg::M_OUT_INC: begin
                // Limits are taken as they stand: a lowered limit freezes the value rather than pulling it back.
                if (nav_hit) next_r.menu = plam_pkg::M_OUT_DEC;
                else if (rep_hit) begin
                    next_r.tune.manipulated_output =
                        plam_step(r.tune.manipulated_output, 1'b1, out_high_limit);
                end
            end
            plam_pkg::M_OUT_DEC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_OUT_STORE;
                else if (rep_hit) begin
                    next_r.tune.manipulated_output =
                        plam_step(r.tune.manipulated_output, 1'b0, out_low_limit);
                end
            end
            plam_pkg::M_OUT_STORE: begin
                if (nav_hit) next_r.menu = plam_pkg::M_OUT_EXIT;
                else if (sel_hit) begin
                    next_r.store = '{1'b1, plam_pkg::ST_OUTPUT, r.tune.manipulated_output};
                end
            end
            plam_pkg::M_OUT_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_OUT_INC;
                else if (sel_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
            end
            plam_pkg::M_CTL_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_AM_ITEM;
                else if (sel_hit) next_r.menu = plam_pkg::M_TUNE_ENTRY;
            end
            plam_pkg::M_AM_ITEM: begin
                // The setpoint item is handled elsewhere, so navigate skips on to the output item.
                if (nav_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
                else if (sel_hit) next_r.tune.manual_mode = ~r.tune.manual_mode;
            end
            plam_pkg::M_TUNE_ENTRY: begin
                // With the control function off, select here is a dead end by intent.
                if (nav_hit) next_r.menu = plam_pkg::M_QUIT;
                else if (sel_hit && pid_enabled) next_r.menu = plam_pkg::M_GAIN_ITEM;
            end
            plam_pkg::M_GAIN_ITEM: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TI_ITEM;
                else if (sel_hit) next_r.menu = plam_pkg::M_GAIN_INC;
            end
            plam_pkg::M_GAIN_INC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_GAIN_DEC;
                else if (rep_hit) begin
                    next_r.tune.proportional_gain =
                        8'(plam_step(gain_wide, 1'b1, {8'h00, `PLAM_GAIN_MAX}));
                end
            end
            plam_pkg::M_GAIN_DEC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_GAIN_STORE;
                else if (rep_hit) begin
                    next_r.tune.proportional_gain = 8'(plam_step(gain_wide, 1'b0, 16'h0000));
                end
            end
            plam_pkg::M_GAIN_STORE: begin
                if (nav_hit) next_r.menu = plam_pkg::M_GAIN_EXIT;
                else if (sel_hit) next_r.store = '{1'b1, plam_pkg::ST_GAIN, gain_wide};
            end
            plam_pkg::M_GAIN_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_GAIN_INC;
                else if (sel_hit) next_r.menu = plam_pkg::M_GAIN_ITEM;
            end
            plam_pkg::M_TI_ITEM: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TD_ITEM;
                else if (sel_hit) next_r.menu = plam_pkg::M_TI_INC;
            end
            plam_pkg::M_TI_INC: begin
                // Both times saturate at TIME_MAX; their units are minutes per repeat and seconds.
                if (nav_hit) next_r.menu = plam_pkg::M_TI_DEC;
                else if (rep_hit) begin
                    next_r.tune.integral_time = plam_step(r.tune.integral_time, 1'b1, 16'(TIME_MAX));
                end
            end
            plam_pkg::M_TI_DEC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TI_STORE;
                else if (rep_hit) begin
                    next_r.tune.integral_time = plam_step(r.tune.integral_time, 1'b0, 16'h0000);
                end
            end
            plam_pkg::M_TI_STORE: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TI_EXIT;
                else if (sel_hit) next_r.store = '{1'b1, plam_pkg::ST_INTEGRAL, r.tune.integral_time};
            end
            plam_pkg::M_TI_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TI_INC;
                else if (sel_hit) next_r.menu = plam_pkg::M_TI_ITEM;
            end
            plam_pkg::M_TD_ITEM: begin
                if (nav_hit) next_r.menu = plam_pkg::M_ACT_ITEM;
                else if (sel_hit) next_r.menu = plam_pkg::M_TD_INC;
            end
            plam_pkg::M_TD_INC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TD_DEC;
                else if (rep_hit) begin
                    next_r.tune.derivative_time = plam_step(r.tune.derivative_time, 1'b1, 16'(TIME_MAX));
                end
            end
            plam_pkg::M_TD_DEC: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TD_STORE;
                else if (rep_hit) begin
                    next_r.tune.derivative_time = plam_step(r.tune.derivative_time, 1'b0, 16'h0000);
                end
            end
            plam_pkg::M_TD_STORE: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TD_EXIT;
                else if (sel_hit) begin
                    next_r.store = '{1'b1, plam_pkg::ST_DERIVATIVE, r.tune.derivative_time};
                end
            end
            plam_pkg::M_TD_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TD_INC;
                else if (sel_hit) next_r.menu = plam_pkg::M_TD_ITEM;
            end
            plam_pkg::M_ACT_ITEM: begin
                if (nav_hit) next_r.menu = plam_pkg::M_LOOP_EXIT;
                else if (sel_hit) next_r.tune.reverse_action = ~r.tune.reverse_action;
            end
            plam_pkg::M_LOOP_EXIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_GAIN_ITEM;
                else if (sel_hit) next_r.menu = plam_pkg::M_QUIT;
            end
            plam_pkg::M_QUIT: begin
                if (nav_hit) next_r.menu = plam_pkg::M_TEST_BRANCH;
                else if (sel_hit) next_r.menu = plam_pkg::M_MONITOR;
            end
            plam_pkg::M_TEST_BRANCH: begin
                // The test-output branch lives outside this block; an insertion hands back here.
                if (nav_hit || sel_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
            end
            plam_pkg::M_MAIN_MENU: begin
                if (nav_hit || sel_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
            end
            plam_pkg::M_MONITOR: begin
                // Any tool insertion re-enters local adjustment at the output item.
                if (nav_hit || sel_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
            end
            default: begin
                // Unused codes recover to the output item on a tool insertion.
                if (nav_hit || sel_hit) next_r.menu = plam_pkg::M_OUT_ITEM;
            end
        endcase

        // A branch that becomes unavailable drops the operator back to its entry.
        if (!pid_enabled && next_r.menu >= plam_pkg::M_GAIN_ITEM && next_r.menu <= plam_pkg::M_LOOP_EXIT) begin
            next_r.menu = plam_pkg::M_TUNE_ENTRY;
        end

        // A held insertion that entered an option must not go on to ramp its value.
        if (next_r.menu != r.menu) begin
            next_r.rep_ok = 1'b0;
        end else if (sel_hit) begin
            next_r.rep_ok = 1'b1;
        end

        // A zero time switches its action off; the flags spare the algorithm a compare.
        next_r.int_act  = (next_r.tune.integral_time != 16'h0000);
        next_r.der_act  = (next_r.tune.derivative_time != 16'h0000);
        next_r.local_on = (next_r.menu != plam_pkg::M_MONITOR);
    end

    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            r <= '{nav_sync: 2'h0, sel_sync: 2'h0, nav_deb: 1'b0, sel_deb: 1'b0,
                   nav_cnt: 32'h0, sel_cnt: 32'h0, rep_cnt: 32'h0, rep_ok: 1'b0,
                   menu: plam_pkg::M_MONITOR,
                   tune: '{`PLAM_OUT_RST, `PLAM_GAIN_RST, `PLAM_TI_RST, `PLAM_TD_RST, 1'b0, 1'b0},
                   store: '{1'b0, plam_pkg::ST_OUTPUT, 16'h0000},
                   int_act: 1'b0, der_act: 1'b0, local_on: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Every output is a register bit, so the display side never sees a glitch.
    assign menu_state        = r.menu;
    assign tuning            = r.tune;
    assign store             = r.store;
    assign integral_active   = r.int_act;
    assign derivative_active = r.der_act;
    assign local_active      = r.local_on;
endmodule : plam_menu

// ---- hw/plam_defs.svh ----
`ifndef PLAM_DEFS_SVH
`define PLAM_DEFS_SVH
`define PLAM_GAIN_MAX          8'h64
`define PLAM_OUT_RST           16'h0000
`define PLAM_GAIN_RST          8'h01
`define PLAM_TI_RST            16'h0000
`define PLAM_TD_RST            16'h0000
`define PLAM_DEB_NS            5000000
`define PLAM_DEB_CYC           ((`PLAM_DEB_NS + 9) / 10)
`define PLAM_REP_NS            100000000
`define PLAM_REP_CYC           (`PLAM_REP_NS / 10)
`endif

// ---- hw/plam_pkg.sv ----
package plam_pkg;
    typedef enum logic [4:0] {
        M_OUT_ITEM, M_OUT_INC, M_OUT_DEC, M_OUT_STORE, M_OUT_EXIT,
        M_CTL_EXIT, M_AM_ITEM,
        M_TUNE_ENTRY,
        M_GAIN_ITEM, M_GAIN_INC, M_GAIN_DEC, M_GAIN_STORE, M_GAIN_EXIT,
        M_TI_ITEM, M_TI_INC, M_TI_DEC, M_TI_STORE, M_TI_EXIT,
        M_TD_ITEM, M_TD_INC, M_TD_DEC, M_TD_STORE, M_TD_EXIT,
        M_ACT_ITEM, M_LOOP_EXIT,
        M_QUIT, M_TEST_BRANCH, M_MAIN_MENU, M_MONITOR
    } plam_menu_t;

    typedef enum logic [1:0] {
        ST_OUTPUT, ST_GAIN, ST_INTEGRAL, ST_DERIVATIVE
    } plam_store_sel_t;

    typedef struct packed {
        logic [15:0] manipulated_output;
        logic [7:0]  proportional_gain;
        logic [15:0] integral_time;
        logic [15:0] derivative_time;
        logic        reverse_action;
        logic        manual_mode;
    } plam_tuning_t;

    typedef struct packed {
        logic            store_req;
        plam_store_sel_t store_sel;
        logic [15:0]     store_data;
    } plam_store_t;
endpackage : plam_pkg

// ---- sim/plam_menu_monitor.sv ----
`timescale 1ns/1ns
module plam_menu_monitor #(
    parameter int TIME_MAX = 16'hffff
) (
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire logic              nav_tool,
    input wire logic              sel_tool,
    input wire logic              pid_enabled,
    input wire logic [15:0]       out_low_limit,
    input wire logic [15:0]       out_high_limit,
    input plam_pkg::plam_menu_t   menu_state,
    input plam_pkg::plam_tuning_t tuning,
    input plam_pkg::plam_store_t  store,
    input wire logic              integral_active,
    input wire logic              derivative_active,
    input wire logic              local_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    AST_STORE_PULSE: assert property (store.store_req |=> !store.store_req)
        else $error("store request wider than one cycle");
    AST_STORE_SRC: assert property (store.store_req |-> $past(menu_state) inside {plam_pkg::M_OUT_STORE,
        plam_pkg::M_GAIN_STORE, plam_pkg::M_TI_STORE, plam_pkg::M_TD_STORE})
        else $error("store request outside a store option");
    AST_OUT_HIGH: assert property ((menu_state == plam_pkg::M_OUT_INC &&
        tuning.manipulated_output >= out_high_limit) |=> tuning.manipulated_output <= $past(tuning.manipulated_output))
        else $error("output raised past upper limit");
    AST_GAIN_RANGE: assert property (tuning.proportional_gain <= 8'h64)
        else $error("gain above 100");
    AST_TIME_RANGE: assert property (tuning.integral_time <= TIME_MAX && tuning.derivative_time <= TIME_MAX)
        else $error("time above limit");
    // A one-cycle lag behind the value is allowed, so only settled values are compared.
    AST_INT_ACTIVE: assert property ($stable(tuning.integral_time) |->
        integral_active == (tuning.integral_time != 16'h0000))
        else $error("integral active flag wrong");
    AST_LOCAL: assert property ($stable(menu_state) |-> local_active == (menu_state != plam_pkg::M_MONITOR))
        else $error("local active flag wrong");
    AST_TUNE_LOCK: assert property ((!pid_enabled && !$past(pid_enabled) &&
        menu_state == plam_pkg::M_TUNE_ENTRY) |=> menu_state != plam_pkg::M_GAIN_ITEM)
        else $error("tuning entered with control disabled");
    AST_MOVE_DEB: assert property ($changed(menu_state) |-> $past(nav_tool, 4) || $past(sel_tool, 4))
        else $error("menu moved without a held tool");
endmodule : plam_menu_monitor

// ---- sim/plam_operator.sv ----
`timescale 1ns/1ns
module plam_operator (
    input wire logic sys_clk,
    output logic     nav_tool,
    output logic     sel_tool
);
    initial begin
        nav_tool = 1'b0;
        sel_tool = 1'b0;
    end
    // Removal is held long enough to be debounced, or the next insertion would be lost.
    task automatic apply(input logic nav, input int hold);
        @(negedge sys_clk);
        nav_tool <= nav;
        sel_tool <= !nav;
        repeat (hold) @(negedge sys_clk);
        nav_tool <= 1'b0;
        sel_tool <= 1'b0;
        repeat (12) @(negedge sys_clk);
    endtask : apply
endmodule : plam_operator

// ---- sim/test_pid_local_adjust_menu.sv ----
`timescale 1ns/1ns
bind plam_menu plam_menu_monitor #(.TIME_MAX(TIME_MAX)) plam_menu_monitor_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .nav_tool(nav_tool), .sel_tool(sel_tool),
    .pid_enabled(pid_enabled), .out_low_limit(out_low_limit), .out_high_limit(out_high_limit),
    .menu_state(menu_state), .tuning(tuning), .store(store), .integral_active(integral_active),
    .derivative_active(derivative_active), .local_active(local_active)
);
module test_pid_local_adjust_menu;
    logic                   sys_clk;
    logic                   rst_b;
    logic                   pid_enabled;
    logic                   nav_tool;
    logic                   sel_tool;
    plam_pkg::plam_menu_t   menu_state;
    plam_pkg::plam_tuning_t tuning;
    plam_pkg::plam_store_t  store;
    plam_pkg::plam_store_t  last_store;
    logic                   integral_active;
    logic                   derivative_active;
    logic                   local_active;
    int                     error_cnt;
    int                     n_compared;

    plam_menu #(.DEB_CYC(4), .REP_CYC(8), .TIME_MAX(6)) plam_menu_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .nav_tool(nav_tool), .sel_tool(sel_tool),
        .pid_enabled(pid_enabled), .out_low_limit(16'h0003), .out_high_limit(16'h0005),
        .menu_state(menu_state), .tuning(tuning), .store(store), .integral_active(integral_active),
        .derivative_active(derivative_active), .local_active(local_active)
    );
    plam_operator plam_operator_i (.sys_clk(sys_clk), .nav_tool(nav_tool), .sel_tool(sel_tool));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (store.store_req === 1'b1) last_store <= store;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic at(input logic [4:0] exp);
        check("menu", 16'(menu_state), 16'(exp));
    endtask : at
    task automatic nav(input int hold = 12);
        plam_operator_i.apply(1'b1, hold);
    endtask : nav
    task automatic sel(input int hold = 12);
        plam_operator_i.apply(1'b0, hold);
    endtask : sel
    function automatic logic [15:0] val(input int k);
        case (k)
            0: return {8'h00, tuning.proportional_gain};
            1: return tuning.integral_time;
            default: return tuning.derivative_time;
        endcase
    endfunction : val

    task automatic test_reset();
        at(plam_pkg::M_MONITOR);
        check("gain", 16'(tuning.proportional_gain), 16'h0001);
        check("local", 16'(local_active), 16'h0000);
        sel(2);
        at(plam_pkg::M_MONITOR);
        sel();
        at(plam_pkg::M_OUT_ITEM);
    endtask : test_reset

    task automatic test_output();
        sel();
        at(plam_pkg::M_OUT_INC);
        check("output", tuning.manipulated_output, 16'h0000);
        sel(120);
        check("output", tuning.manipulated_output, 16'h0005);
        nav();
        at(plam_pkg::M_OUT_DEC);
        sel(120);
        check("output", tuning.manipulated_output, 16'h0003);
        nav();
        at(plam_pkg::M_OUT_STORE);
        sel();
        check("store sel", 16'(last_store.store_sel), 16'(plam_pkg::ST_OUTPUT));
        check("store data", last_store.store_data, 16'h0003);
        nav();
        at(plam_pkg::M_OUT_EXIT);
        nav();
        at(plam_pkg::M_OUT_INC);
        repeat (3) nav();
        sel();
        at(plam_pkg::M_OUT_ITEM);
    endtask : test_output

    task automatic test_control();
        nav();
        at(plam_pkg::M_CTL_EXIT);
        nav();
        at(plam_pkg::M_AM_ITEM);
        sel();
        check("manual", 16'(tuning.manual_mode), 16'h0001);
        nav();
        at(plam_pkg::M_OUT_ITEM);
        nav();
        sel();
        at(plam_pkg::M_TUNE_ENTRY);
        pid_enabled = 1'b0;
        sel();
        at(plam_pkg::M_TUNE_ENTRY);
        pid_enabled = 1'b1;
        sel();
        at(plam_pkg::M_GAIN_ITEM);
    endtask : test_control

    task automatic test_adjust(input int k);
        logic [4:0]  base;
        logic [15:0] top;
        base = 5'(8 + 5 * k);
        top = (k == 0) ? 16'h0064 : 16'h0006;
        sel();
        at(base + 5'h01);
        sel((k == 0) ? 900 : 120);
        check("ramp up", val(k), top);
        if (k > 0) check("active", 16'(k == 1 ? integral_active : derivative_active), 16'h0001);
        nav();
        at(base + 5'h02);
        sel((k == 0) ? 900 : 120);
        check("ramp down", val(k), 16'h0000);
        if (k > 0) check("active", 16'(k == 1 ? integral_active : derivative_active), 16'h0000);
        nav();
        sel();
        check("store sel", 16'(last_store.store_sel), 16'(k + 1));
        check("store data", last_store.store_data, 16'h0000);
        nav();
        at(base + 5'h04);
        sel();
        at(base);
        nav();
        at(base + 5'h05);
    endtask : test_adjust

    task automatic test_action();
        sel();
        check("reverse", 16'(tuning.reverse_action), 16'h0001);
        sel();
        check("reverse", 16'(tuning.reverse_action), 16'h0000);
        nav();
        at(plam_pkg::M_LOOP_EXIT);
        nav();
        at(plam_pkg::M_GAIN_ITEM);
        repeat (4) nav();
        sel();
        at(plam_pkg::M_QUIT);
        nav();
        at(plam_pkg::M_TEST_BRANCH);
        sel();
        nav();
        sel();
        nav();
        at(plam_pkg::M_QUIT);
        sel();
        at(plam_pkg::M_MONITOR);
        check("local", 16'(local_active), 16'h0000);
    endtask : test_action

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rst_b = 1'b0;
        pid_enabled = 1'b1;
        last_store = '1;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        test_reset();
        test_output();
        test_control();
        for (int k = 0; k < 3; k++) test_adjust(k);
        test_action();
        print_verdict();
    end
    // The whole sequence needs about 4000 cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : test_pid_local_adjust_menu
